// file: rtl/pcs_pkg.sv
// shared constants, encodings and carrier types of the sequencing block
package pcs_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int PC_W      = 13;
  localparam int LIT_W     = 11;
  localparam int LATCH_W   = 5;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;
  localparam int FP_W      = 8;
  localparam int EA_W      = 9;
  localparam int DIR_W     = 7;
  localparam int ADDR_W    = 12;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses on the bus)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_PC_LOW   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_PC_LATCH = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_FILE_PTR = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_BANK     = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_EFF_ADDR = 12'h010;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BANK_BIT_POS = 0;
  localparam int JMP_HI_MSB   = 4;
  localparam int JMP_HI_LSB   = 3;
  localparam logic [PC_W-1:0]    PC_RST       = 13'h0000;
  localparam logic [LATCH_W-1:0] LATCH_RST    = 5'h00;
  localparam logic [FP_W-1:0]    FP_RST       = 8'h00;
  localparam logic               BANK_RST     = 1'b0;
  localparam logic [PC_W-1:0]    IRQ_VECTOR   = 13'h0004;
  localparam logic [DIR_W-1:0]   IND_LOC      = 7'h00;
  localparam logic [7:0]         IND_SELF_VAL = 8'h00;
  localparam logic [PC_W-1:0]    PC_ONE       = 13'h0001;

  // ----------------------------------------------------------------------
  // sequencing requests from the instruction decoder
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_STEP   = 3'b001,
    OP_JUMP   = 3'b010,
    OP_CALL   = 3'b011,
    OP_RET    = 3'b100,
    OP_RETLIT = 3'b101,
    OP_RETINT = 3'b110,
    OP_IRQ    = 3'b111
  } pcs_op_t;

  typedef struct packed {
    pcs_op_t            op;
    logic [LIT_W-1:0]   lit;
  } pcs_instr_t;

  // data-memory access: core side and memory side share the layout
  typedef struct packed {
    logic               valid;
    logic               we;
    logic [EA_W-1:0]    addr;
    logic [7:0]         wdata;
  } pcs_facc_t;

endpackage

// file: rtl/pcs_ret_stack.sv
// eight-deep circular return-address stack with hidden pointer
module pcs_ret_stack
  import pcs_pkg::*;
(
  input  wire logic            pclk,      // system clock
  input  wire logic            presetn,   // async reset, active low
  input  wire logic            ce,        // clock enable
  input  wire logic            push,      // store wdata on top
  input  wire logic            pop,       // drop the top entry
  input  wire logic [PC_W-1:0] wdata,     // address to store
  output logic      [PC_W-1:0] top        // most recent entry
);

  logic [PC_W-1:0]      mem [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr_q;
  logic [STK_PTR_W-1:0] ptr_dec;

  // ----------------------------------------------------------------------
  // pointer
  // ----------------------------------------------------------------------
  // the pointer wraps both ways; no overflow flag exists by design
  assign ptr_dec = ptr_q - 3'h1;
  assign top     = mem[ptr_dec];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 3'h0;
    end else if (ce && push) begin
      ptr_q <= ptr_q + 3'h1;
    end else if (ce && pop) begin
      ptr_q <= ptr_dec;
    end
  end

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // entries are not reset: a pop before any push returns stale data
  always_ff @(posedge pclk) begin
    if (ce && push) begin
      mem[ptr_q] <= wdata;
    end
  end

endmodule

// file: rtl/pcs_ind_map.sv
// redirects accesses of the indirect location through the file pointer
module pcs_ind_map
  import pcs_pkg::*;
(
  input  wire pcs_facc_t       core_acc,  // access from the decoder
  input  wire logic [FP_W-1:0] fptr,      // file pointer value
  input  wire logic            bank,      // indirect bank bit
  output pcs_facc_t            mem_acc,   // access to data memory
  output logic                 self_sel,  // indirect access of itself
  output logic [EA_W-1:0]      eff_addr   // indirect effective address
);

  logic is_ind;

  assign eff_addr = {bank, fptr};
  assign is_ind   = core_acc.addr[DIR_W-1:0] == IND_LOC;
  assign self_sel = is_ind && (eff_addr[DIR_W-1:0] == IND_LOC);

  // a self-selecting access never reaches memory
  assign mem_acc.valid = core_acc.valid && !self_sel;
  assign mem_acc.we    = core_acc.we && !self_sel;
  assign mem_acc.addr  = is_ind ? eff_addr : core_acc.addr;
  assign mem_acc.wdata = core_acc.wdata;

endmodule

// file: rtl/pcs_core_seq.sv
// program counter, return stack and indirect addressing with apb access
//
// Behaviour
// - program counter is thirteen bits wide
// - low pc byte readable and writable by software
// - upper pc bits hidden, never written directly by software
// - every reset clears the whole program counter
// - low byte write loads upper bits from latch
// - call or jump takes top bits from latch
// - eight by thirteen stack outside both memories
// - software cannot reach the stack pointer
// - call pushes pc plus one, interrupt vectoring pushes the pc
// - all three return kinds pop into pc
// - push and pop leave the latch alone
// - stack wraps, ninth push overwrites the first
// - no overflow or underflow status exists
// - indirect location redirects through the file pointer
// - indirect read of itself returns zero
// - indirect write of itself changes nothing
// - effective address is bank bit plus pointer
module pcs_core_seq
  import pcs_pkg::*;
(
  input  wire logic              pclk,        // system clock
  input  wire logic              presetn,     // async reset, active low
  input  wire logic              ce,          // clock enable, freezes state
  input  wire logic              psel,        // apb select
  input  wire logic              penable,     // apb access phase
  input  wire logic              pwrite,      // apb direction
  input  wire logic [ADDR_W-1:0] paddr,       // apb byte address
  input  wire logic [31:0]       pwdata,      // apb write data
  output logic      [31:0]       prdata,      // apb read data
  output logic                   pready,      // apb ready
  output logic                   pslverr,     // apb error
  input  wire pcs_instr_t        instr,       // sequencing request
  output logic      [PC_W-1:0]   pc,          // current program counter
  input  wire pcs_facc_t         core_acc,    // core data access
  input  wire logic [7:0]        mem_rdata,   // memory read data
  output pcs_facc_t              mem_acc,     // access to data memory
  output logic      [7:0]        core_rdata,  // read data to core
  output logic                   core_rvalid  // read data valid
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    pc_d;
  logic [LATCH_W-1:0] latch_q;
  logic [FP_W-1:0]    fptr_q;
  logic               bank_q;
  logic [31:0]        prdata_q;
  logic               perr_q;
  logic [7:0]         rdata_q;
  logic               rvalid_q;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic        setup_ph;
  logic        access_ph;
  logic        wr_fire;
  logic        hit_pc_low;
  logic        hit_latch;
  logic        hit_fptr;
  logic        hit_bank;
  logic        hit_eff;
  logic        hit_any;
  logic        wr_pc_low;
  logic        wr_latch;
  logic        wr_fptr;
  logic        wr_bank;
  logic [31:0] rd_mux;

  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable;
  assign pready     = access_ph && ce;
  assign wr_fire    = pready && pwrite;

  assign hit_pc_low = paddr == OFF_PC_LOW;
  assign hit_latch  = paddr == OFF_PC_LATCH;
  assign hit_fptr   = paddr == OFF_FILE_PTR;
  assign hit_bank   = paddr == OFF_BANK;
  assign hit_eff    = paddr == OFF_EFF_ADDR;
  // no offset reaches the stack pointer or the stored entries
  assign hit_any    = hit_pc_low || hit_latch || hit_fptr
                   || hit_bank || hit_eff;

  assign wr_pc_low  = wr_fire && hit_pc_low;
  assign wr_latch   = wr_fire && hit_latch;
  assign wr_fptr    = wr_fire && hit_fptr;
  assign wr_bank    = wr_fire && hit_bank;

  // only the low byte of the pc is visible; upper bits never read back
  assign rd_mux =
      hit_pc_low ? {24'h00_0000, pc_q[7:0]} :
      hit_latch  ? {27'h000_0000, latch_q} :
      hit_fptr   ? {24'h00_0000, fptr_q} :
      hit_bank   ? {31'h0000_0000, bank_q} :
      hit_eff    ? {23'h00_0000, bank_q, fptr_q} :
                   32'h0000_0000;

  assign prdata  = prdata_q;
  assign pslverr = pready && perr_q;

  // ----------------------------------------------------------------------
  // bus response capture
  // ----------------------------------------------------------------------
  // read data is sampled in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      perr_q   <= 1'b0;
    end else if (ce && setup_ph) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      perr_q   <= !hit_any;
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  // the latch only changes by software; stack traffic never touches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= LATCH_RST;
    end else if (ce && wr_latch) begin
      latch_q <= pwdata[LATCH_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fptr_q <= FP_RST;
    end else if (ce && wr_fptr) begin
      fptr_q <= pwdata[FP_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= BANK_RST;
    end else if (ce && wr_bank) begin
      bank_q <= pwdata[BANK_BIT_POS];
    end
  end

  // ----------------------------------------------------------------------
  // return stack
  // ----------------------------------------------------------------------
  logic            stk_push;
  logic            stk_pop;
  logic [PC_W-1:0] stk_wdata;
  logic [PC_W-1:0] stk_top;
  logic [PC_W-1:0] pc_seq;
  logic [PC_W-1:0] pc_far;
  logic            do_instr;
  logic            is_ret;

  assign pc_seq   = pc_q + PC_ONE;
  // far target: top two bits from the latch, the rest from the literal
  assign pc_far   = {latch_q[JMP_HI_MSB:JMP_HI_LSB], instr.lit};
  // a software write of the low byte takes the cycle over the decoder
  assign do_instr = ce && !wr_pc_low;
  assign is_ret   = (instr.op == OP_RET) || (instr.op == OP_RETLIT)
                 || (instr.op == OP_RETINT);

  assign stk_push = do_instr
                 && ((instr.op == OP_CALL) || (instr.op == OP_IRQ));
  assign stk_pop  = do_instr && is_ret;
  // a call returns past itself; an interrupt resumes the cut instruction
  assign stk_wdata = (instr.op == OP_CALL) ? pc_seq : pc_q;

  pcs_ret_stack u_stack (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .push    (stk_push),
    .pop     (stk_pop),
    .wdata   (stk_wdata),
    .top     (stk_top)
  );

  // ----------------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    if (wr_pc_low) begin
      pc_d = {latch_q, pwdata[7:0]};
    end else begin
      case (instr.op)
        OP_NONE: begin
          pc_d = pc_q;
        end
        OP_STEP: begin
          pc_d = pc_seq;
        end
        OP_JUMP: begin
          pc_d = pc_far;
        end
        OP_CALL: begin
          pc_d = pc_far;
        end
        OP_IRQ: begin
          pc_d = IRQ_VECTOR;
        end
        OP_RET: begin
          pc_d = stk_top;
        end
        OP_RETLIT: begin
          pc_d = stk_top;
        end
        OP_RETINT: begin
          pc_d = stk_top;
        end
        default: begin
          pc_d = pc_q;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= PC_RST;
    end else if (ce) begin
      pc_q <= pc_d;
    end
  end

  assign pc = pc_q;

  // ----------------------------------------------------------------------
  // indirect addressing
  // ----------------------------------------------------------------------
  logic            self_sel;
  logic [EA_W-1:0] eff_addr;

  pcs_ind_map u_ind (
    .core_acc (core_acc),
    .fptr     (fptr_q),
    .bank     (bank_q),
    .mem_acc  (mem_acc),
    .self_sel (self_sel),
    .eff_addr (eff_addr)
  );

  // memory answers reads combinationally; the result is registered and held until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= core_acc.valid && !core_acc.we;
      if (core_acc.valid && !core_acc.we) begin
        rdata_q <= self_sel ? IND_SELF_VAL : mem_rdata;
      end
    end
  end

  assign core_rdata  = rdata_q;
  assign core_rvalid = rvalid_q;

endmodule

// file: testbench/pcs_core_seq_props.sv
// assertions on the ports of the sequencing block
module pcs_core_seq_props
  import pcs_pkg::*;
(
  input wire logic              pclk,        // clock
  input wire logic              presetn,     // reset, active low
  input wire logic              ce,          // clock enable
  input wire logic              psel,        // apb select
  input wire logic              penable,     // apb access
  input wire logic              pwrite,      // apb direction
  input wire logic [ADDR_W-1:0] paddr,       // apb address
  input wire logic [31:0]       pwdata,      // apb write data
  input wire logic [31:0]       prdata,      // apb read data
  input wire logic              pready,      // apb ready
  input wire logic              pslverr,     // apb error
  input wire pcs_instr_t        instr,       // sequencing request
  input wire logic [PC_W-1:0]   pc,          // program counter
  input wire pcs_facc_t         core_acc,    // core access
  input wire logic [7:0]        mem_rdata,   // memory data
  input wire pcs_facc_t         mem_acc,     // memory access
  input wire logic [7:0]        core_rdata,  // core read data
  input wire logic              core_rvalid  // core read valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  logic pcw;
  logic run;
  assign pcw = pready && pwrite && paddr == OFF_PC_LOW;
  // a low-byte write wins over the decoder, so ops count only without it
  assign run = ce && !pcw;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  pc_low_load_a: assert property (pcw |=> pc[7:0] == $past(pwdata[7:0]))
    else $error("pc low byte not loaded");
  jump_target_a: assert property (run && instr.op == OP_JUMP |=> pc[10:0] == $past(instr.lit))
    else $error("jump target wrong");
  irq_vector_a: assert property (run && instr.op == OP_IRQ |=> pc == IRQ_VECTOR)
    else $error("interrupt vector wrong");
  step_incr_a: assert property (run && instr.op == OP_STEP |=> pc == $past(pc) + PC_ONE)
    else $error("pc step wrong");
  hold_freeze_a: assert property (!ce |=> $stable(pc))
    else $error("pc moved while frozen");
  call_ret_a: assert property (run && instr.op == OP_CALL ##1 run && instr.op == OP_RET
    |=> pc == $past(pc, 2) + PC_ONE)
    else $error("return address wrong");
  self_block_a: assert property (mem_acc.valid |-> mem_acc.addr[6:0] != IND_LOC)
    else $error("indirect location reached memory");
  direct_pass_a: assert property (core_acc.valid && core_acc.addr[6:0] != IND_LOC
    |-> mem_acc == core_acc)
    else $error("direct access altered");
  rd_return_a: assert property (ce && core_acc.valid && !core_acc.we && mem_acc.valid
    |=> core_rvalid && core_rdata == $past(mem_rdata))
    else $error("read data not returned");
  cover property (pcw);
  cover property (run && instr.op == OP_CALL);
  cover property (core_acc.valid && core_acc.addr[6:0] == IND_LOC);
endmodule

bind pcs_core_seq pcs_core_seq_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr), .pc(pc),
  .core_acc(core_acc), .mem_rdata(mem_rdata), .mem_acc(mem_acc),
  .core_rdata(core_rdata), .core_rvalid(core_rvalid));

// file: testbench/pcs_mem_model.sv
// data memory partner: 512 bytes, reads answered in the same cycle
module pcs_mem_model
  import pcs_pkg::*;
(
  input wire logic      pclk,       // system clock
  input wire pcs_facc_t mem_acc,    // access from the block
  output logic [7:0]    mem_rdata,  // read data
  output int            wr_cnt      // writes seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [512];
  logic [7:0] last_q;
  initial begin
    for (int i = 0; i < 512; i++) mem_q[i] = 8'h00;
    wr_cnt = 0;
    last_q = 8'h00;
  end
  // idle bus shows the inverse of the last value, so stale data never passes
  assign mem_rdata = (mem_acc.valid && !mem_acc.we) ? mem_q[mem_acc.addr] : ~last_q;
  always @(posedge pclk) begin
    if (mem_acc.valid && mem_acc.we) begin
      mem_q[mem_acc.addr] <= mem_acc.wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (mem_acc.valid && !mem_acc.we) last_q <= mem_q[mem_acc.addr];
  end
endmodule

// file: testbench/tb_top.sv
// self-checking bench of the sequencing block
module tb_top
  import pcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, core_rvalid, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [31:0] seed = 32'h0000_003D;
  pcs_instr_t instr;
  logic [PC_W-1:0] pc;
  pcs_facc_t core_acc, mem_acc;
  logic [7:0] mem_rdata, core_rdata;
  int wr_cnt, miscompares, total_checks, cyc, pcm, latm, sp, n;
  int stk[8];

  pcs_core_seq dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr(instr), .pc(pc), .core_acc(core_acc),
    .mem_rdata(mem_rdata), .mem_acc(mem_acc), .core_rdata(core_rdata),
    .core_rvalid(core_rvalid));
  pcs_mem_model u_mem (.pclk(pclk), .mem_acc(mem_acc), .mem_rdata(mem_rdata),
    .wr_cnt(wr_cnt));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [ADDR_W-1:0] a, logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // entered just after an edge; the op is applied at the next edge
  task automatic op(pcs_op_t o, logic [10:0] l);
    instr <= '{o, l};
    @(posedge pclk);
    if (ce) begin
      case (o)
        OP_STEP: pcm = (pcm + 1) % 8192;
        OP_JUMP: pcm = (((latm >> 3) & 3) << 11) | l;
        OP_CALL: begin
          stk[sp] = (pcm + 1) % 8192;
          sp = (sp + 1) % 8;
          pcm = (((latm >> 3) & 3) << 11) | l;
        end
        OP_IRQ: begin
          stk[sp] = pcm;
          sp = (sp + 1) % 8;
          pcm = IRQ_VECTOR;
        end
        OP_NONE: pcm = pcm;
        default: begin
          sp = (sp + 7) % 8;
          pcm = stk[sp];
        end
      endcase
    end
    #1 chk("pc", pc, pcm);
  endtask
  task automatic dacc(logic w, logic [EA_W-1:0] a, logic [7:0] wd);
    core_acc <= '{1'b1, w, a, wd};
    @(posedge pclk);
    core_acc <= '0;
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    {presetn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
    instr = '{OP_NONE, 11'h000};
    core_acc = '0;
    {miscompares, total_checks, cyc, pcm, latm, sp} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    ce <= 1'b1;
    chk("pc reset", pc, 0);
    apb(0, OFF_PC_LOW, 0);
    chk("pc low reset", rd, 0);
    apb(1, OFF_PC_LATCH, 32'hFFFF_FFFF);
    latm = 31;
    apb(0, OFF_PC_LATCH, 0);
    chk("latch", rd, 32'h0000_001F);
    d = rnd();
    apb(1, OFF_PC_LOW, d);
    pcm = (latm << 8) | d[7:0];
    #1 chk("pc load", pc, pcm);
    apb(0, OFF_PC_LOW, 0);
    chk("pc low", rd, {24'h00_0000, d[7:0]});
    apb(0, 12'hFFC, 0);
    chk("unmapped", {31'h0, er}, 1);
    for (int k = 0; k < 2; k++) begin
      latm = k ? 8 : 16;
      apb(1, OFF_PC_LATCH, latm);
      op(OP_JUMP, rnd());
      op(OP_STEP, 0);
    end
    for (int i = 0; i < 10; i++) op(OP_CALL, rnd());
    for (int i = 0; i < 8; i++) op(pcs_op_t'(3'(4 + i % 3)), 0);
    op(OP_IRQ, 0);
    op(OP_CALL, rnd());
    op(OP_RET, 0);
    op(OP_RETINT, 0);
    instr <= '{OP_STEP, 11'h000};
    ce <= 1'b0;
    op(OP_STEP, 0);
    ce <= 1'b1;
    op(OP_NONE, 0);
    apb(0, OFF_PC_LATCH, 0);
    chk("latch kept", rd, latm);
    apb(1, OFF_FILE_PTR, 32'h0000_0025);
    apb(1, OFF_BANK, 1);
    apb(1, OFF_EFF_ADDR, 0);
    chk("eff wr err", {31'h0, er}, 0);
    apb(0, OFF_EFF_ADDR, 0);
    chk("eff addr", rd, 32'h0000_0125);
    d = rnd();
    dacc(1, 9'h000, d[7:0]);
    dacc(0, 9'h125, 0);
    chk("direct rd", core_rdata, d[7:0]);
    dacc(0, 9'h080, 0);
    chk("ind rd", {core_rvalid, core_rdata}, {1'b1, d[7:0]});
    apb(1, OFF_FILE_PTR, 32'h0000_0080);
    apb(1, OFF_BANK, 0);
    n = wr_cnt;
    dacc(1, 9'h000, 8'h5A);
    chk("self wr", wr_cnt, n);
    dacc(0, 9'h000, 0);
    chk("self rd", core_rdata, IND_SELF_VAL);
    presetn <= 1'b0;
    @(posedge pclk);
    #1 chk("pc rerun", pc, 0);
    presetn <= 1'b1;
    stop_test();
  end
endmodule
